// file: inc/e1omg_defs.vh
// Register map, field positions, reset values and timing for the E1 overhead block
`ifndef E1OMG_DEFS_VH
`define E1OMG_DEFS_VH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define E1OMG_IDX_STATUS 12'h05f
`define E1OMG_IDX_IRQ_EN 12'h060
`define E1OMG_IDX_FLAGS 12'h061
`define E1OMG_IDX_MODE 12'h062

// ----------------------------------------------------------------------
// Status bits
// ----------------------------------------------------------------------
`define E1OMG_ST_LINK 0
`define E1OMG_ST_CBLK 1
`define E1OMG_ST_CALM 2

// ----------------------------------------------------------------------
// Interrupt enable and flag bits (same layout)
// ----------------------------------------------------------------------
`define E1OMG_IRQ_LINK 0
`define E1OMG_IRQ_CBLK 1
`define E1OMG_IRQ_CALM 2
`define E1OMG_IRQ_FAR 3
`define E1OMG_IRQ_NTBLK 4
`define E1OMG_IRQ_NTCRC 5

// ----------------------------------------------------------------------
// Mode bits and reset value
// ----------------------------------------------------------------------
`define E1OMG_MD_FRAME_OFF 0
`define E1OMG_MD_CRC_GEN 1
`define E1OMG_MD_SIG_GEN 2
`define E1OMG_MD_MOD_CRC 3
`define E1OMG_MD_EBIT_OFF 4
`define E1OMG_MD_INTL_OFF 5
`define E1OMG_MD_EXTRA_OFF 6
`define E1OMG_MODE_RESET 7'h06

// ----------------------------------------------------------------------
// Monitor figures and timing
// ----------------------------------------------------------------------
`define E1OMG_CLK_HZ 10000000
`define E1OMG_ALARM_TIME_MS 10
`define E1OMG_SECOND_MS 1000
`define E1OMG_BLK_ERR_MIN 11'h3de
`define E1OMG_BLK_SECONDS 5
`define E1OMG_CW_NTCRC_A 4'h2
`define E1OMG_CW_NTCRC_B 4'h3
`define E1OMG_CW_NTBLK_A 4'h1
`define E1OMG_CW_NTBLK_B 4'h3

`endif

// file: hdl/e1omg_blk_window.v
// Per-second zero E-bit counter with a five-second history of seconds at or above the error threshold
`timescale 1ns/10ps
`include "e1omg_defs.vh"

module e1omg_blk_window (
  input wire pclk,
  input wire presetn,
  input wire active,
  input wire sec_tick,
  input wire zero_e,
  output reg cont_err
);

  reg [10:0] zero_cnt;
  reg [`E1OMG_BLK_SECONDS-1:0] hist;

  // ----------------------------------------------------------------------
  // Counting
  // ----------------------------------------------------------------------
  // Saturating count; one E bit per sub-multiframe stays well below 2047
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      zero_cnt <= 11'h000;
      hist <= {`E1OMG_BLK_SECONDS{1'b0}};
      cont_err <= 1'b0;
    end else if (!active) begin
      zero_cnt <= 11'h000;
      hist <= {`E1OMG_BLK_SECONDS{1'b0}};
      cont_err <= 1'b0;
    end else if (sec_tick) begin
      zero_cnt <= zero_e ? 11'h001 : 11'h000;
      hist <= {hist[`E1OMG_BLK_SECONDS-2:0],
               (zero_cnt >= `E1OMG_BLK_ERR_MIN)};
      cont_err <= &{hist[`E1OMG_BLK_SECONDS-2:0],
                    (zero_cnt >= `E1OMG_BLK_ERR_MIN)};
    end else if (zero_e && zero_cnt != 11'h7ff) begin
      zero_cnt <= zero_cnt + 11'h001;
    end
  end

endmodule // e1omg_blk_window

// file: hdl/e1omg_overhead.v
// E1 overhead monitor, interrupt registers and frame-generation mode
//
// How it works
// - A=1, E=0 for 10ms sets alarm
// - >=990 zero E per second, 5 seconds
// - Two of last three Sa7 zero
// - Sa6 codeword 0010/0011 flags NT CRC
// - Sa6 codeword 0001/0011 flags NT block error
// - Zero E bit flags far-end block error
// - No far-end detection without CRC alignment
// - Change flags on either status transition
// - Flags clear only by writing one
// - Interrupt needs flag and enable; enables reset zero
// - Extra bits replaced while signalling generation is on, unless disabled
// - International bit replaced when CRC generation off, unless disabled
// - One zero E bit per sub-multiframe with pending CRC errors
// - E bits take international values in two cases
// - Both disables set leave E untouched
// - Signalling and CRC enables; modified CRC needs CRC
// - Frame-generation off overrides all generation
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/10ps
`include "e1omg_defs.vh"

module e1omg_overhead #(
  parameter ALARM_CYCLES = `E1OMG_ALARM_TIME_MS * (`E1OMG_CLK_HZ / 1000),
  parameter SECOND_CYCLES = `E1OMG_SECOND_MS * (`E1OMG_CLK_HZ / 1000)
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  output wire irq_n,
  input wire crc_align_lost,
  input wire basic_align_ok,
  input wire rx_a_bit,
  input wire rx_e_strobe,
  input wire rx_e_bit,
  input wire rx_sa7_strobe,
  input wire rx_sa7_bit,
  input wire rx_sa6_cw_strobe,
  input wire [3:0] rx_sa6_cw,
  input wire rx_crc_err,
  input wire rx_crc_err_smf,
  input wire [2:0] extra_bits_val,
  input wire [1:0] intl_bits_val,
  input wire tx_bit_in,
  input wire tx_x_pos,
  input wire [1:0] tx_x_idx,
  input wire tx_si_fas_pos,
  input wire tx_si_nfas_pos,
  input wire tx_e_pos,
  input wire tx_e_smf,
  output reg tx_bit_out,
  output wire basic_frame_gen,
  output wire sig_multiframe_gen,
  output wire crc_multiframe_gen,
  output wire modified_crc_gen
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function [11:0] reg_addr;
    input [11:0] idx;
    begin
      reg_addr = {idx[9:0], 2'b00};
    end
  endfunction

  function at_least_two_zero;
    input [2:0] bits;
    begin
      at_least_two_zero = (!bits[0] && !bits[1]) || (!bits[0] && !bits[2]) ||
                          (!bits[1] && !bits[2]);
    end
  endfunction

  // ----------------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------------
  reg [5:0] irq_en;
  reg [5:0] irq_flags;
  reg [6:0] mode;
  wire [2:0] status;
  reg st_calm, st_link, st_cblk;
  reg [2:0] status_prev;
  reg [16:0] alarm_cnt;
  reg [23:0] sec_cnt;
  reg sec_tick;
  reg [2:0] sa7_hist;
  reg [1:0] e_err_pend;
  reg next_tx_bit;
  reg [5:0] hw_set;
  wire cont_blk;
  wire wr_access;
  wire rd_setup;
  wire hit_status;
  wire hit_en;
  wire hit_flags;
  wire hit_mode;
  wire mapped;
  wire alarm_cond;
  wire crc_aligned;
  wire frame_off;
  wire crc_gen;
  wire sig_gen;

  assign crc_aligned = !crc_align_lost;
  assign frame_off = mode[`E1OMG_MD_FRAME_OFF];
  assign status = {st_calm, st_cblk, st_link};

  // ----------------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------------
  // Read data is captured in the setup cycle, so no wait states are needed
  assign hit_status = (paddr == reg_addr(`E1OMG_IDX_STATUS));
  assign hit_en = (paddr == reg_addr(`E1OMG_IDX_IRQ_EN));
  assign hit_flags = (paddr == reg_addr(`E1OMG_IDX_FLAGS));
  assign hit_mode = (paddr == reg_addr(`E1OMG_IDX_MODE));
  assign mapped = hit_status || hit_en || hit_flags || hit_mode;
  assign pready = psel && penable;
  assign pslverr = psel && penable && !mapped;
  assign wr_access = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (rd_setup) begin
      if (hit_status) begin
        prdata <= {29'h0, status};
      end else if (hit_en) begin
        prdata <= {26'h0, irq_en};
      end else if (hit_flags) begin
        prdata <= {26'h0, irq_flags};
      end else if (hit_mode) begin
        prdata <= {25'h0, mode};
      end else begin
        prdata <= 32'h00000000;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Writable controls
  // ----------------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_en <= 6'h00;
      mode <= `E1OMG_MODE_RESET;
    end else if (wr_access) begin
      if (hit_en) begin
        irq_en <= pwdata[5:0];
      end else if (hit_mode) begin
        mode <= pwdata[6:0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Time base
  // ----------------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sec_cnt <= 24'h000000;
      sec_tick <= 1'b0;
    end else if (sec_cnt == SECOND_CYCLES - 1) begin
      sec_cnt <= 24'h000000;
      sec_tick <= 1'b1;
    end else begin
      sec_cnt <= sec_cnt + 24'h000001;
      sec_tick <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Continuous alarm with block error
  // ----------------------------------------------------------------------
  // The condition is re-evaluated on every received E bit; a single good
  // E bit or a dropped A bit restarts the 10 ms window
  reg alarm_seen;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alarm_seen <= 1'b0;
    end else if (!crc_aligned) begin
      alarm_seen <= 1'b0;
    end else if (rx_e_strobe) begin
      alarm_seen <= rx_a_bit && !rx_e_bit;
    end
  end

  assign alarm_cond = alarm_seen && crc_aligned && rx_a_bit;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alarm_cnt <= 17'h0;
      st_calm <= 1'b0;
    end else if (!alarm_cond) begin
      alarm_cnt <= 17'h0;
      st_calm <= 1'b0;
    end else if (alarm_cnt == ALARM_CYCLES - 1) begin
      st_calm <= 1'b1;
    end else begin
      alarm_cnt <= alarm_cnt + 17'h1;
    end
  end

  // ----------------------------------------------------------------------
  // Continuous block error
  // ----------------------------------------------------------------------
  e1omg_blk_window u_blk_window (
    .pclk(pclk),
    .presetn(presetn),
    .active(crc_aligned),
    .sec_tick(sec_tick),
    .zero_e(rx_e_strobe && !rx_e_bit),
    .cont_err(cont_blk)
  );

  // ----------------------------------------------------------------------
  // Link identification and status history
  // ----------------------------------------------------------------------
  // History resets to ones so a fresh alignment starts with no signal
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sa7_hist <= 3'h7;
      st_link <= 1'b0;
      st_cblk <= 1'b0;
      status_prev <= 3'h0;
    end else begin
      st_cblk <= cont_blk;
      status_prev <= status;
      if (!basic_align_ok) begin
        sa7_hist <= 3'h7;
        st_link <= 1'b0;
      end else if (rx_sa7_strobe) begin
        sa7_hist <= {sa7_hist[1:0], rx_sa7_bit};
        st_link <= at_least_two_zero({sa7_hist[1:0], rx_sa7_bit});
      end
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt flags
  // ----------------------------------------------------------------------
  always @* begin
    hw_set = 6'h00;
    hw_set[`E1OMG_IRQ_LINK] = status[`E1OMG_ST_LINK] ^
                              status_prev[`E1OMG_ST_LINK];
    hw_set[`E1OMG_IRQ_CBLK] = status[`E1OMG_ST_CBLK] ^
                              status_prev[`E1OMG_ST_CBLK];
    hw_set[`E1OMG_IRQ_CALM] = status[`E1OMG_ST_CALM] ^
                              status_prev[`E1OMG_ST_CALM];
    // Suspended entirely while out of CRC multiframe alignment
    hw_set[`E1OMG_IRQ_FAR] = crc_aligned && rx_e_strobe &&
                             !rx_e_bit;
    hw_set[`E1OMG_IRQ_NTBLK] = rx_sa6_cw_strobe &&
      (rx_sa6_cw == `E1OMG_CW_NTBLK_A ||
       rx_sa6_cw == `E1OMG_CW_NTBLK_B);
    hw_set[`E1OMG_IRQ_NTCRC] = rx_sa6_cw_strobe &&
      (rx_sa6_cw == `E1OMG_CW_NTCRC_A ||
       rx_sa6_cw == `E1OMG_CW_NTCRC_B);
  end

  // A new event in the clearing cycle survives the clear
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_flags <= 6'h00;
    end else if (wr_access && hit_flags) begin
      irq_flags <= (irq_flags & ~pwdata[5:0]) | hw_set;
    end else begin
      irq_flags <= irq_flags | hw_set;
    end
  end

  assign irq_n = ~|(irq_flags & irq_en);

  // ----------------------------------------------------------------------
  // Generation mode
  // ----------------------------------------------------------------------
  assign basic_frame_gen = !frame_off;
  assign crc_gen = !frame_off && mode[`E1OMG_MD_CRC_GEN];
  assign sig_gen = !frame_off && mode[`E1OMG_MD_SIG_GEN];
  assign crc_multiframe_gen = crc_gen;
  assign sig_multiframe_gen = sig_gen;
  assign modified_crc_gen = crc_gen && mode[`E1OMG_MD_MOD_CRC];

  // ----------------------------------------------------------------------
  // E-bit error backlog
  // ----------------------------------------------------------------------
  // One pending error per sub-multiframe; errors arriving faster than the
  // E slots are merged, a limit of a one-deep backlog
  wire e_slot_used;

  assign e_slot_used = tx_e_pos && crc_gen && !mode[`E1OMG_MD_EBIT_OFF] &&
                       crc_aligned;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      e_err_pend <= 2'b00;
    end else begin
      if (e_slot_used && !tx_e_smf) begin
        e_err_pend[0] <= rx_crc_err && !rx_crc_err_smf;
      end else if (rx_crc_err && !rx_crc_err_smf) begin
        e_err_pend[0] <= 1'b1;
      end
      if (e_slot_used && tx_e_smf) begin
        e_err_pend[1] <= rx_crc_err && rx_crc_err_smf;
      end else if (rx_crc_err && rx_crc_err_smf) begin
        e_err_pend[1] <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Transmit overhead insertion
  // ----------------------------------------------------------------------
  always @* begin
    next_tx_bit = tx_bit_in;
    if (!frame_off) begin
      if (tx_x_pos) begin
        if (sig_gen && !mode[`E1OMG_MD_EXTRA_OFF]) begin
          next_tx_bit = extra_bits_val[tx_x_idx];
        end
      end else if (tx_si_fas_pos) begin
        if (!crc_gen && !mode[`E1OMG_MD_INTL_OFF]) begin
          next_tx_bit = intl_bits_val[1];
        end
      end else if (tx_si_nfas_pos) begin
        if (!crc_gen && !mode[`E1OMG_MD_INTL_OFF]) begin
          next_tx_bit = intl_bits_val[0];
        end
      end else if (tx_e_pos && crc_gen) begin
        if (e_slot_used) begin
          next_tx_bit = !e_err_pend[tx_e_smf];
        end else if (!mode[`E1OMG_MD_EBIT_OFF] ||
                     !mode[`E1OMG_MD_INTL_OFF]) begin
          next_tx_bit = tx_e_smf ? intl_bits_val[0] :
                                   intl_bits_val[1];
        end else begin
          next_tx_bit = tx_bit_in;
        end
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_bit_out <= 1'b1;
    end else begin
      tx_bit_out <= next_tx_bit;
    end
  end

endmodule // e1omg_overhead

// file: verification/e1omg_overhead_sva.sv
// Port-level assertions for the E1 overhead block
`timescale 1ns/10ps
`include "e1omg_defs.vh"
module e1omg_overhead_sva (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire irq_n,
  input wire crc_align_lost,
  input wire [2:0] extra_bits_val,
  input wire [1:0] intl_bits_val,
  input wire tx_bit_in,
  input wire tx_x_pos,
  input wire [1:0] tx_x_idx,
  input wire tx_si_fas_pos,
  input wire tx_e_pos,
  input wire tx_e_smf,
  input wire tx_bit_out,
  input wire basic_frame_gen,
  input wire sig_multiframe_gen,
  input wire crc_multiframe_gen,
  input wire modified_crc_gen
);
  // ------------------------------------------------------------
  // Shadow of mode and enables, fed by completed writes
  // ------------------------------------------------------------
  reg [6:0] md;
  reg [5:0] en;
  wire wr = psel && penable && pwrite;
  wire x_val = extra_bits_val[tx_x_idx];
  wire e_val = tx_e_smf ? intl_bits_val[0] : intl_bits_val[1];
  wire [3:0] gen = {basic_frame_gen, sig_multiframe_gen,
                    crc_multiframe_gen, modified_crc_gen};
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      md <= `E1OMG_MODE_RESET;
      en <= 6'h00;
    end else if (wr && paddr == 12'h188) begin
      md <= pwdata[6:0];
    end else if (wr && paddr == 12'h180) begin
      en <= pwdata[5:0];
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  frame_off_a: assert property (
    md[0] |-> gen == 4'h0) else $error("generation not stopped");
  sig_gen_a: assert property (
    !md[0] |-> gen[3:1] == {1'b1, md[2], md[1]})
    else $error("generation enables wrong");
  mod_crc_a: assert property (
    !md[0] |-> gen[0] == (md[3] && md[1])) else $error("modified crc wrong");
  extra_bits_a: assert property (
    tx_x_pos && tx_x_idx != 2'h3 && sig_multiframe_gen && !md[6]
    |=> tx_bit_out == $past(x_val)) else $error("extra bit not replaced");
  extra_pass_a: assert property (
    tx_x_pos && md[6] |=> tx_bit_out == $past(tx_bit_in))
    else $error("extra bit altered");
  intl_bit_a: assert property (
    tx_si_fas_pos && basic_frame_gen && !crc_multiframe_gen && !md[5]
    |=> tx_bit_out == $past(intl_bits_val[1])) else $error("si bit wrong");
  ebit_intl_a: assert property (
    tx_e_pos && crc_multiframe_gen && (md[4] ? !md[5] : crc_align_lost)
    |=> tx_bit_out == $past(e_val)) else $error("e bit not intl value");
  ebit_keep_a: assert property (
    tx_e_pos && crc_multiframe_gen && md[4] && md[5]
    |=> tx_bit_out == $past(tx_bit_in)) else $error("e bit altered");
  irq_mask_a: assert property (
    en == 6'h00 |-> irq_n) else $error("interrupt while all masked");
  cover property (tx_e_pos && crc_multiframe_gen && !md[4]);
  cover property ($fell(irq_n));
  cover property (tx_x_pos && !md[6]);
endmodule // e1omg_overhead_sva

// file: verification/e1omg_far_end.sv
// Behavioural model of the remote terminal sending overhead bits
`timescale 1ns/10ps
module e1omg_far_end (
  input wire pclk,
  output logic rx_a_bit,
  output logic rx_e_strobe,
  output logic rx_e_bit,
  output logic rx_sa7_strobe,
  output logic rx_sa7_bit,
  output logic rx_sa6_cw_strobe,
  output logic [3:0] rx_sa6_cw
);
  initial begin
    rx_a_bit = 1'b0;
    rx_e_strobe = 1'b0;
    rx_e_bit = 1'b1;
    rx_sa7_strobe = 1'b0;
    rx_sa7_bit = 1'b1;
    rx_sa6_cw_strobe = 1'b0;
    rx_sa6_cw = 4'h0;
  end
  // Value lines show the inverse between strobes, so sampling them
  // off the strobe reads a wrong bit; gap slows the sender down
  task send_e(input logic b, input int gap);
    @(posedge pclk);
    rx_e_strobe <= 1'b1;
    rx_e_bit <= b;
    @(posedge pclk);
    rx_e_strobe <= 1'b0;
    rx_e_bit <= ~b;
    repeat (gap) @(posedge pclk);
  endtask
  task send_sa7(input logic b);
    @(posedge pclk);
    rx_sa7_strobe <= 1'b1;
    rx_sa7_bit <= b;
    @(posedge pclk);
    rx_sa7_strobe <= 1'b0;
    rx_sa7_bit <= ~b;
  endtask
  task send_cw(input logic [3:0] cw);
    @(posedge pclk);
    rx_sa6_cw_strobe <= 1'b1;
    rx_sa6_cw <= cw;
    @(posedge pclk);
    rx_sa6_cw_strobe <= 1'b0;
    rx_sa6_cw <= ~cw;
  endtask
  task set_a(input logic b);
    @(posedge pclk);
    rx_a_bit <= b;
  endtask
endmodule // e1omg_far_end

// file: verification/e1omg_overhead_bench.sv
// Self-checking bench for the E1 overhead block
`timescale 1ns/10ps
`include "e1omg_defs.vh"
module e1omg_overhead_bench;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, crc_align_lost = 1'b0, basic_align_ok = 1'b0;
  logic rx_crc_err = 1'b0, rx_crc_err_smf = 1'b0, tx_bit_in = 1'b0;
  logic tx_x_pos = 1'b0, fas = 1'b0, nfas = 1'b0, tx_e_pos = 1'b0;
  logic tx_e_smf = 1'b0, slverr;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, d, fx;
  logic [2:0] xv = 3'b101;
  logic [1:0] sv = 2'b10, tx_x_idx = 2'h0;
  wire [31:0] prdata;
  wire pready, pslverr, irq_n, tx_bit_out, ra, es, eb, ss, sb, cs;
  wire [3:0] cw;
  wire [3:0] gen;
  int mismatches = 0, compares = 0, i;
  always #50 pclk = ~pclk;
  e1omg_far_end far (.pclk(pclk), .rx_a_bit(ra), .rx_e_strobe(es),
    .rx_e_bit(eb), .rx_sa7_strobe(ss), .rx_sa7_bit(sb),
    .rx_sa6_cw_strobe(cs), .rx_sa6_cw(cw));
  e1omg_overhead #(.ALARM_CYCLES(20), .SECOND_CYCLES(2000)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq_n(irq_n),
    .crc_align_lost(crc_align_lost), .basic_align_ok(basic_align_ok),
    .rx_a_bit(ra), .rx_e_strobe(es), .rx_e_bit(eb), .rx_sa7_strobe(ss),
    .rx_sa7_bit(sb), .rx_sa6_cw_strobe(cs), .rx_sa6_cw(cw),
    .rx_crc_err(rx_crc_err), .rx_crc_err_smf(rx_crc_err_smf),
    .extra_bits_val(xv), .intl_bits_val(sv), .tx_bit_in(tx_bit_in),
    .tx_x_pos(tx_x_pos), .tx_x_idx(tx_x_idx), .tx_si_fas_pos(fas),
    .tx_si_nfas_pos(nfas), .tx_e_pos(tx_e_pos), .tx_e_smf(tx_e_smf),
    .tx_bit_out(tx_bit_out), .basic_frame_gen(gen[3]),
    .sig_multiframe_gen(gen[2]), .crc_multiframe_gen(gen[1]),
    .modified_crc_gen(gen[0]));
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task stop_test;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task apb(input logic [11:0] idx, input logic w, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx[9:0], 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    d = prdata;
    slverr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      mismatches++;
      stop_test();
    end
  endtask
  task rd_chk(input logic [11:0] idx, input logic [31:0] exp, input string nm);
    repeat (4) @(posedge pclk);
    apb(idx, 1'b0, 32'h0);
    check(nm, exp, d);
  endtask
  // kind 0 extra bit, 1 FAS bit 1, 2 E bit, 3 NFAS bit 1
  task tx_slot(input int k, input logic [1:0] ix, input logic b, input logic e);
    @(posedge pclk);
    tx_x_pos <= (k == 0);
    fas <= (k == 1);
    tx_e_pos <= (k == 2);
    nfas <= (k == 3);
    tx_x_idx <= ix;
    tx_e_smf <= ix[0];
    tx_bit_in <= b;
    @(posedge pclk);
    {tx_x_pos, fas, tx_e_pos, nfas} <= 4'h0;
    #1 check("tx bit", e, tx_bit_out);
  endtask
  task crc_err(input logic smf);
    @(posedge pclk);
    rx_crc_err <= 1'b1;
    rx_crc_err_smf <= smf;
    @(posedge pclk);
    rx_crc_err <= 1'b0;
  endtask
  // ------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(`E1OMG_IDX_IRQ_EN, 32'h0, "irq enable");
    rd_chk(`E1OMG_IDX_MODE, 32'h06, "mode");
    apb(`E1OMG_IDX_STATUS, 1'b1, 32'hff);
    rd_chk(`E1OMG_IDX_STATUS, 32'h0, "status");
    rd_chk(12'h070, 32'h0, "unmapped");
    check("slverr", 32'h1, slverr);
    $display("reset and map test done");
    for (i = 0; i < 16; i++) begin
      far.send_cw(i[3:0]);
      fx = {(i == 2 || i == 3), (i == 1 || i == 3), 4'h0};
      rd_chk(`E1OMG_IDX_FLAGS, fx, "codeword flags");
      apb(`E1OMG_IDX_FLAGS, 1'b1, 32'h0);
      rd_chk(`E1OMG_IDX_FLAGS, fx, "flags kept");
      apb(`E1OMG_IDX_FLAGS, 1'b1, 32'h30);
      rd_chk(`E1OMG_IDX_FLAGS, 32'h0, "flags cleared");
    end
    $display("codeword test done");
    apb(`E1OMG_IDX_IRQ_EN, 1'b1, 32'h08);
    far.send_e(1'b0, 0);
    rd_chk(`E1OMG_IDX_FLAGS, 32'h08, "far flag");
    #1 check("irq", 32'h0, irq_n);
    apb(`E1OMG_IDX_IRQ_EN, 1'b1, 32'h0);
    #1 check("irq masked", 32'h1, irq_n);
    apb(`E1OMG_IDX_FLAGS, 1'b1, 32'h08);
    apb(`E1OMG_IDX_IRQ_EN, 1'b1, 32'h3f);
    #1 check("irq cleared", 32'h1, irq_n);
    @(posedge pclk) crc_align_lost <= 1'b1;
    far.send_e(1'b0, 3);
    rd_chk(`E1OMG_IDX_FLAGS, 32'h0, "far flag unaligned");
    @(posedge pclk) crc_align_lost <= 1'b0;
    $display("far-end and interrupt test done");
    @(posedge pclk) basic_align_ok <= 1'b1;
    for (i = 0; i < 3; i++) far.send_sa7(1'b1);
    far.send_sa7(1'b0);
    rd_chk(`E1OMG_IDX_STATUS, 32'h0, "link one zero");
    far.send_sa7(1'b0);
    rd_chk(`E1OMG_IDX_STATUS, 32'h1, "link two zeros");
    rd_chk(`E1OMG_IDX_FLAGS, 32'h1, "link change");
    apb(`E1OMG_IDX_FLAGS, 1'b1, 32'h1);
    far.send_sa7(1'b1);
    far.send_sa7(1'b1);
    rd_chk(`E1OMG_IDX_STATUS, 32'h0, "link gone");
    rd_chk(`E1OMG_IDX_FLAGS, 32'h1, "link fall change");
    @(posedge pclk) basic_align_ok <= 1'b0;
    for (i = 0; i < 2; i++) far.send_sa7(1'b0);
    rd_chk(`E1OMG_IDX_STATUS, 32'h0, "link unaligned");
    apb(`E1OMG_IDX_FLAGS, 1'b1, 32'h3f);
    far.set_a(1'b1);
    far.send_e(1'b0, 0);
    rd_chk(`E1OMG_IDX_STATUS, 32'h0, "alarm early");
    repeat (20) @(posedge pclk);
    rd_chk(`E1OMG_IDX_STATUS, 32'h4, "alarm set");
    rd_chk(`E1OMG_IDX_FLAGS, 32'h0c, "alarm change");
    apb(`E1OMG_IDX_FLAGS, 1'b1, 32'h0c);
    far.send_e(1'b1, 0);
    rd_chk(`E1OMG_IDX_STATUS, 32'h0, "alarm end");
    rd_chk(`E1OMG_IDX_FLAGS, 32'h04, "alarm fall change");
    far.set_a(1'b0);
    apb(`E1OMG_IDX_FLAGS, 1'b1, 32'h3f);
    $display("link and alarm test done");
    for (i = 0; i < 4000; i++) far.send_e(1'b0, 0);
    rd_chk(`E1OMG_IDX_STATUS, 32'h0, "block four seconds");
    for (i = 0; i < 2500; i++) far.send_e(1'b0, 0);
    rd_chk(`E1OMG_IDX_STATUS, 32'h2, "block five seconds");
    rd_chk(`E1OMG_IDX_FLAGS, 32'h0a, "block change");
    repeat (4100) @(posedge pclk);
    rd_chk(`E1OMG_IDX_STATUS, 32'h0, "block quiet second");
    $display("block window test done");
    @(posedge pclk) xv <= 3'b011;
    for (i = 0; i < 3; i++) tx_slot(0, i[1:0], ~xv[i], xv[i]);
    apb(`E1OMG_IDX_MODE, 1'b1, 32'h46);
    tx_slot(0, 2'h1, ~xv[1], ~xv[1]);
    apb(`E1OMG_IDX_MODE, 1'b1, 32'h06);
    crc_err(1'b0);
    tx_slot(2, 2'h0, 1'b1, 1'b0);
    tx_slot(2, 2'h0, 1'b1, 1'b1);
    crc_err(1'b1);
    tx_slot(2, 2'h1, 1'b1, 1'b0);
    @(posedge pclk) crc_align_lost <= 1'b1;
    tx_slot(2, 2'h0, 1'b0, sv[1]);
    tx_slot(2, 2'h1, 1'b1, sv[0]);
    @(posedge pclk) crc_align_lost <= 1'b0;
    apb(`E1OMG_IDX_MODE, 1'b1, 32'h16);
    tx_slot(2, 2'h0, 1'b0, sv[1]);
    apb(`E1OMG_IDX_MODE, 1'b1, 32'h36);
    tx_slot(2, 2'h0, 1'b0, 1'b0);
    tx_slot(2, 2'h1, 1'b1, 1'b1);
    @(posedge pclk) sv <= 2'b01;
    apb(`E1OMG_IDX_MODE, 1'b1, 32'h04);
    tx_slot(1, 2'h0, ~sv[1], sv[1]);
    tx_slot(3, 2'h0, ~sv[0], sv[0]);
    apb(`E1OMG_IDX_MODE, 1'b1, 32'h24);
    tx_slot(1, 2'h0, ~sv[1], ~sv[1]);
    apb(`E1OMG_IDX_MODE, 1'b1, 32'h08);
    #1 check("gen", 32'h8, gen);
    apb(`E1OMG_IDX_MODE, 1'b1, 32'h0a);
    #1 check("gen", 32'hb, gen);
    apb(`E1OMG_IDX_MODE, 1'b1, 32'hff);
    #1 check("gen", 32'h0, gen);
    rd_chk(`E1OMG_IDX_MODE, 32'h7f, "mode");
    $display("transmit and mode test done");
    stop_test();
  end
endmodule // e1omg_overhead_bench
bind e1omg_overhead e1omg_overhead_sva chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .irq_n(irq_n), .crc_align_lost(crc_align_lost),
  .extra_bits_val(extra_bits_val), .intl_bits_val(intl_bits_val),
  .tx_bit_in(tx_bit_in), .tx_x_pos(tx_x_pos), .tx_x_idx(tx_x_idx),
  .tx_si_fas_pos(tx_si_fas_pos), .tx_e_pos(tx_e_pos), .tx_e_smf(tx_e_smf),
  .tx_bit_out(tx_bit_out), .basic_frame_gen(basic_frame_gen),
  .sig_multiframe_gen(sig_multiframe_gen),
  .crc_multiframe_gen(crc_multiframe_gen),
  .modified_crc_gen(modified_crc_gen));
